//--- hdl/traffic_checker_status.sv
/*
 * status, capture and control logic for a memory traffic checker.
 * assumes the traffic generator delivers checked reads (expected vs actual)
 * and request strobes on clk; lock/cal/parity inputs come from other domains.
 */
// Functional notes
// - lock indicator: 1 locked, 0 not
// - 32-bit count of checked read words
// - 32-bit count of read mismatches
// - hold 31-bit first mismatch address
// - read-valid flags before and after first fail
// - sticky 128-bit per-bit pass vector
// - per-bit pass vector of first mismatch
// - expected data at, before, after fail
// - actual data at, before, after fail
// - reread first fail address, store pass vector
// - 96-bit word: requests, reads, clocks since first
// - primary and secondary phase lock indicators
// - 33-bit calibration done plus clock count
// - pass, fail, timeout flags active high
// - active-high generator reset holds traffic
// - active-low global reset clears counters, captures, cal count; not control/irq regs
// - stop-on-error halts traffic, rereads, default off
// - parity status, frozen when not applicable
`timescale 1ns/1ps
module traffic_checker_status
   import traffic_probe_pkg::*;
#(
   parameter int DW = DATA_W
) (
   input  wire logic                 clk,
   input  wire logic                 resetn,
   input  wire logic                 clkEn,
   // ahb-lite slave
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic                      hreadyout,
   output logic                      hresp,
   output logic [31:0]               hrdata,
   // asynchronous status inputs
   input  wire logic                 clkgenLockIn,
   input  wire logic                 phaseAlignIn,
   input  wire logic                 phaseAlignSecIn,
   input  wire logic                 calibDoneIn,
   input  wire logic                 parityErrIn,
   input  wire logic                 parityEnable,
   // traffic generator side
   input  wire rd_check_t            rdCheck,
   input  wire req_obs_t             reqObs,
   input  wire logic                 tgPass,
   input  wire logic                 tgFail,
   input  wire logic                 tgTimeout,
   output logic                      traffic_gen_reset,
   output logic                      global_reset_n,
   output logic                      stop_on_error_mode,
   output logic                      haltTraffic,
   output logic                      rereadReq,
   output logic [ADDR_W-1:0]         rereadAddr,
   output logic                      irq
);

   // capture banks and bus slicing assume the package width
   if (DW != DATA_W) begin : g_widthChk
      $error("data width must match package");
   end

   // two-stage synchronisers; only stage two is read
   logic [4:0] syncA_r, syncB_r;
   wire  [4:0] asyncIn = {parityErrIn, calibDoneIn, phaseAlignSecIn, phaseAlignIn, clkgenLockIn};
   always_ff @(posedge clk) begin
      if (!resetn) begin
         syncA_r <= 5'h00;
         syncB_r <= 5'h00;
      end else if (clkEn) begin
         syncA_r <= asyncIn;
         syncB_r <= syncA_r;
      end
   end
   wire clkgen_lock                = syncB_r[0];
   wire phase_align_lock           = syncB_r[1];
   wire phase_align_lock_secondary = syncB_r[2];
   wire calDone                    = syncB_r[3];
   wire parityNow                  = syncB_r[4];

   // control sources
   logic [2:0] ctrl_r;
   assign traffic_gen_reset  = ctrl_r[CT_TGRST];
   assign stop_on_error_mode = ctrl_r[CT_STOP];
   assign global_reset_n     = resetn & ctrl_r[CT_GRSTN];

   // counters and captures clear on either reset
   wire clr = !global_reset_n || traffic_gen_reset;

   logic [CNT_W-1:0]    read_total_count, mismatch_total_count;
   logic [CNT_W-1:0]    reqCnt_r, rdReqCnt_r, clkCnt_r;
   logic                seenReq_r;
   logic [CALCNT_W-1:0] calCnt_r;
   logic                cmd_parity_status;
   logic [ADDR_W-1:0]   first_fail_addr;
   logic                read_valid_before_fail, read_valid_after_fail;
   logic [DW-1:0]       sticky_pass_vector, first_fail_pass_vector, reread_pass_vector;
   logic [DW-1:0]       expected_at_fail, expected_before_fail, expected_after_fail;
   logic [DW-1:0]       actual_at_fail, actual_before_fail, actual_after_fail;
   logic [DW-1:0]       prevExp_r, prevAct_r;
   logic                prevValid_r;
   logic                traffic_pass_flag, traffic_fail_flag, traffic_timeout_flag;
   logic                rereadPend_r;
   cap_state_t          capState_r;

   wire [DW-1:0] bitPass  = ~(rdCheck.expected ^ rdCheck.actual);
   wire          mismatch = rdCheck.valid && (rdCheck.expected != rdCheck.actual);
   wire          firstHit = mismatch && capState_r == CAP_IDLE;
   wire          isReread = rdCheck.valid && rereadPend_r && rdCheck.addr == first_fail_addr;
   wire [CNT_W-1:0] calCntLo = calCnt_r;
   wire [CALCNT_W:0]      calib_progress_word = {calDone, calCntLo};
   wire [3*CNT_W-1:0]     stall_count_word    = {reqCnt_r, rdReqCnt_r, clkCnt_r};

   always_ff @(posedge clk) begin
      if (clr) begin
         read_total_count     <= '0;
         mismatch_total_count <= '0;
         reqCnt_r             <= '0;
         rdReqCnt_r           <= '0;
         clkCnt_r             <= '0;
         seenReq_r            <= 1'b0;
         traffic_pass_flag    <= 1'b0;
         traffic_fail_flag    <= 1'b0;
         traffic_timeout_flag <= 1'b0;
      end else if (clkEn) begin
         if (rdCheck.valid) read_total_count <= read_total_count + 1'b1;
         if (mismatch) mismatch_total_count <= mismatch_total_count + 1'b1;
         if (reqObs.req) reqCnt_r <= reqCnt_r + 1'b1;
         if (reqObs.req && reqObs.isRead) rdReqCnt_r <= rdReqCnt_r + 1'b1;
         if (reqObs.req) seenReq_r <= 1'b1;
         if (seenReq_r || reqObs.req) clkCnt_r <= clkCnt_r + 1'b1;
         traffic_pass_flag    <= tgPass;
         traffic_fail_flag    <= tgFail;
         traffic_timeout_flag <= tgTimeout;
      end
   end

   // calibration clock count runs until done; reruns only on global reset
   always_ff @(posedge clk) begin
      if (!global_reset_n) begin
         calCnt_r          <= '0;
         cmd_parity_status <= 1'b0;
      end else if (clkEn) begin
         if (!calDone) calCnt_r <= calCnt_r + 1'b1;
         if (parityEnable) cmd_parity_status <= parityNow;
      end
   end

   // previous read kept so the word before a failure can be captured
   always_ff @(posedge clk) begin
      if (clr) begin
         prevExp_r   <= '0;
         prevAct_r   <= '0;
         prevValid_r <= 1'b0;
      end else if (clkEn && rdCheck.valid) begin
         prevExp_r   <= rdCheck.expected;
         prevAct_r   <= rdCheck.actual;
         prevValid_r <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (clr) begin
         capState_r             <= CAP_IDLE;
         first_fail_addr        <= '0;
         read_valid_before_fail <= 1'b0;
         read_valid_after_fail  <= 1'b0;
         first_fail_pass_vector <= '1;
         expected_at_fail       <= '0;
         expected_before_fail   <= '0;
         expected_after_fail    <= '0;
         actual_at_fail         <= '0;
         actual_before_fail     <= '0;
         actual_after_fail      <= '0;
      end else if (clkEn) begin
         case (capState_r)
            CAP_IDLE: begin
               if (firstHit) begin
                  capState_r             <= CAP_AFTER;
                  first_fail_addr        <= rdCheck.addr;
                  first_fail_pass_vector <= bitPass;
                  expected_at_fail       <= rdCheck.expected;
                  actual_at_fail         <= rdCheck.actual;
                  expected_before_fail   <= prevExp_r;
                  actual_before_fail     <= prevAct_r;
                  read_valid_before_fail <= prevValid_r;
               end
            end
            CAP_AFTER: begin
               if (rdCheck.valid) begin
                  capState_r            <= CAP_DONE;
                  expected_after_fail   <= rdCheck.expected;
                  actual_after_fail     <= rdCheck.actual;
                  read_valid_after_fail <= 1'b1;
               end
            end
            default: capState_r <= CAP_DONE;
         endcase
      end
   end

   // sticky pass vector; meaningless once stop mode halts traffic
   always_ff @(posedge clk) begin
      if (clr) begin
         sticky_pass_vector <= '1;
      end else if (clkEn && rdCheck.valid) begin
         sticky_pass_vector <= sticky_pass_vector & bitPass;
      end
   end

   // one reread of the first failing address in every error run, requested the cycle after the first mismatch
   always_ff @(posedge clk) begin
      if (clr) begin
         rereadPend_r       <= 1'b0;
         rereadReq          <= 1'b0;
         rereadAddr         <= '0;
         reread_pass_vector <= '1;
         haltTraffic        <= 1'b0;
      end else if (clkEn) begin
         rereadReq <= firstHit;
         if (firstHit) begin
            rereadPend_r <= 1'b1;
            rereadAddr   <= rdCheck.addr;
            haltTraffic  <= stop_on_error_mode;
         end else if (isReread && capState_r != CAP_IDLE) begin
            rereadPend_r       <= 1'b0;
            reread_pass_vector <= bitPass;
         end
      end
   end

   // interrupt status: set wins over read-clear
   logic [IRQ_W-1:0] irqStat_r, irqMask_r;
   logic             calDoneD_r, passD_r, failD_r, tmoD_r;
   wire  [IRQ_W-1:0] irqEv;
   assign irqEv[EV_PASS] = traffic_pass_flag & ~passD_r;
   assign irqEv[EV_FAIL] = traffic_fail_flag & ~failD_r;
   assign irqEv[EV_TMO]  = traffic_timeout_flag & ~tmoD_r;
   assign irqEv[EV_CAL]  = calDone & ~calDoneD_r;
   assign irq = |(irqStat_r & irqMask_r);

   // ahb-lite: zero wait states, always okay
   ahb_addr_t aph_r;
   wire       aphTake = hsel && hready && htrans == HTRANS_NONSEQ;
   wire       rdStat  = aph_r.sel && !aph_r.write && aph_r.addr == OFS_IRQ_STAT;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         aph_r      <= '0;
         ctrl_r     <= CTRL_RESET;
         irqStat_r  <= '0;
         irqMask_r  <= '0;
         calDoneD_r <= 1'b0;
         passD_r    <= 1'b0;
         failD_r    <= 1'b0;
         tmoD_r     <= 1'b0;
      end else if (clkEn) begin
         aph_r      <= '{addr: haddr[11:0], write: hwrite, sel: aphTake};
         calDoneD_r <= calDone;
         passD_r    <= traffic_pass_flag;
         failD_r    <= traffic_fail_flag;
         tmoD_r     <= traffic_timeout_flag;
         irqStat_r  <= (rdStat ? '0 : irqStat_r) | irqEv;
         if (aph_r.sel && aph_r.write) begin
            if (aph_r.addr == OFS_CONTROL) ctrl_r <= hwdata[2:0];
            else if (aph_r.addr == OFS_IRQ_MASK) irqMask_r <= hwdata[IRQ_W-1:0];
         end
      end
   end

   // wide capture banks: bank index from bits 7:4, word from bits 3:2
   wire [DW-1:0] wideBank [WIDE_BANKS];
   assign wideBank[0] = expected_at_fail;
   assign wideBank[1] = expected_before_fail;
   assign wideBank[2] = expected_after_fail;
   assign wideBank[3] = actual_at_fail;
   assign wideBank[4] = actual_before_fail;
   assign wideBank[5] = actual_after_fail;
   assign wideBank[6] = sticky_pass_vector;
   assign wideBank[7] = first_fail_pass_vector;
   assign wideBank[8] = reread_pass_vector;

   wire [11:0] wideOfs   = aph_r.addr - OFS_WIDE_BASE;
   wire        wideHit   = aph_r.addr >= OFS_WIDE_BASE && wideOfs[11:4] < 8'(WIDE_BANKS);
   wire [3:0]  wideBankI = wideOfs[7:4];
   wire [1:0]  wideWord  = wideOfs[3:2];
   wire [DW-1:0] wideSel = wideHit ? wideBank[wideBankI] : '0;
   wire [31:0] wideRd    = wideSel[wideWord*32 +: 32];

   wire [31:0] statusWord = {22'h0, cmd_parity_status, read_valid_after_fail,
                             read_valid_before_fail, traffic_timeout_flag,
                             traffic_fail_flag, traffic_pass_flag, calDone,
                             phase_align_lock_secondary, phase_align_lock, clkgen_lock};

   wire [31:0] rdMux;
   assign rdMux =
      (aph_r.addr == OFS_STATUS)    ? statusWord :
      (aph_r.addr == OFS_CONTROL)   ? {29'h0, ctrl_r} :
      (aph_r.addr == OFS_IRQ_STAT)  ? {28'h0, irqStat_r} :
      (aph_r.addr == OFS_IRQ_MASK)  ? {28'h0, irqMask_r} :
      (aph_r.addr == OFS_READ_CNT)  ? read_total_count :
      (aph_r.addr == OFS_FAIL_CNT)  ? mismatch_total_count :
      (aph_r.addr == OFS_FAIL_ADDR) ? {1'b0, first_fail_addr} :
      (aph_r.addr == OFS_CAL_CNT)   ? calib_progress_word[31:0] :
      (aph_r.addr == OFS_REQ_CNT)   ? stall_count_word[95:64] :
      (aph_r.addr == OFS_RDREQ_CNT) ? stall_count_word[63:32] :
      (aph_r.addr == OFS_CLK_CNT)   ? stall_count_word[31:0] :
      wideRd;
   assign hrdata = (aph_r.sel && !aph_r.write) ? rdMux : 32'h0000_0000;

   // assertions
   a_read_count_step: assert property (@(posedge clk) disable iff (clr)
      clkEn && rdCheck.valid |=> read_total_count == $past(read_total_count) + 1)
      else $error("read count did not step");
   a_fail_count_step: assert property (@(posedge clk) disable iff (clr)
      clkEn && mismatch |=> mismatch_total_count == $past(mismatch_total_count) + 1)
      else $error("mismatch count did not step");
   a_fail_addr_hold: assert property (@(posedge clk) disable iff (clr)
      capState_r != CAP_IDLE |=> $stable(first_fail_addr))
      else $error("first fail address changed");
   sequence firstFailSeq;
      clkEn && firstHit;
   endsequence
   a_capture_first: assert property (@(posedge clk) disable iff (clr)
      firstFailSeq |=> first_fail_pass_vector == $past(bitPass)
         && actual_at_fail == $past(rdCheck.actual))
      else $error("first failure capture wrong");
   a_sticky_clears: assert property (@(posedge clk) disable iff (clr)
      clkEn && rdCheck.valid |=> (sticky_pass_vector & ~$past(bitPass)) == '0)
      else $error("sticky vector missed a failing bit");
   a_reread_issue: assert property (@(posedge clk) disable iff (clr)
      firstFailSeq |=> rereadReq && rereadAddr == $past(rdCheck.addr))
      else $error("reread not issued");
   a_stop_halts: assert property (@(posedge clk) disable iff (clr)
      (firstFailSeq and stop_on_error_mode) |=> haltTraffic)
      else $error("stop mode did not halt traffic");
   a_flag_follow: assert property (@(posedge clk) disable iff (clr)
      clkEn |=> traffic_fail_flag == $past(tgFail))
      else $error("fail flag not following generator");
   a_clear_counters: assert property (@(posedge clk)
      clr |=> read_total_count == '0 && !seenReq_r)
      else $error("counters not cleared by reset");
   a_halt_sticks: assert property (@(posedge clk) disable iff (clr)
      haltTraffic |=> haltTraffic)
      else $error("halt released without reset");
   a_before_capture: assert property (@(posedge clk) disable iff (clr)
      firstFailSeq |=> read_valid_before_fail == $past(prevValid_r)
         && expected_before_fail == $past(prevExp_r))
      else $error("before-fail capture wrong");
   sequence afterReadSeq;
      clkEn && capState_r == CAP_AFTER && rdCheck.valid;
   endsequence
   a_after_capture: assert property (@(posedge clk) disable iff (clr)
      afterReadSeq |=> read_valid_after_fail && actual_after_fail == $past(rdCheck.actual))
      else $error("after-fail capture wrong");
   a_reread_store: assert property (@(posedge clk) disable iff (clr)
      clkEn && isReread && capState_r != CAP_IDLE |=> reread_pass_vector == $past(bitPass))
      else $error("reread result not stored");
   a_stall_clocks: assert property (@(posedge clk) disable iff (clr)
      clkEn && seenReq_r |=> clkCnt_r == $past(clkCnt_r) + 1)
      else $error("clock count did not step");
   a_cal_count: assert property (@(posedge clk) disable iff (!global_reset_n)
      clkEn && !calDone |=> calCnt_r == $past(calCnt_r) + 1)
      else $error("calibration count did not step");
   a_parity_freeze: assert property (@(posedge clk) disable iff (!global_reset_n)
      clkEn && !parityEnable |=> $stable(cmd_parity_status))
      else $error("parity status moved while disabled");
   a_irq_clear: assert property (@(posedge clk) disable iff (!resetn)
      clkEn && rdStat |=> (irqStat_r & ~$past(irqEv)) == '0)
      else $error("interrupt status not cleared by read");

endmodule

//--- hdl/traffic_probe_pkg.sv
/*
 * shared constants and carrier types for the traffic checker status block.
 * assumes a single core clock domain; register map is reached over ahb-lite.
 */
package traffic_probe_pkg;

   localparam int DATA_W    = 128;
   localparam int ADDR_W    = 31;
   localparam int CNT_W     = 32;
   localparam int CALCNT_W  = 32;

   // register byte offsets
   localparam logic [11:0] OFS_STATUS    = 12'h000;
   localparam logic [11:0] OFS_CONTROL   = 12'h004;
   localparam logic [11:0] OFS_IRQ_STAT  = 12'h008;
   localparam logic [11:0] OFS_IRQ_MASK  = 12'h00c;
   localparam logic [11:0] OFS_READ_CNT  = 12'h010;
   localparam logic [11:0] OFS_FAIL_CNT  = 12'h014;
   localparam logic [11:0] OFS_FAIL_ADDR = 12'h018;
   localparam logic [11:0] OFS_CAL_CNT   = 12'h01c;
   localparam logic [11:0] OFS_REQ_CNT   = 12'h020;
   localparam logic [11:0] OFS_RDREQ_CNT = 12'h024;
   localparam logic [11:0] OFS_CLK_CNT   = 12'h028;
   // six 128-bit capture banks, four words each, then three pass vectors
   localparam logic [11:0] OFS_WIDE_BASE = 12'h100;
   localparam int          WIDE_BANKS    = 9;

   // status bit positions
   localparam int ST_LOCK    = 0;
   localparam int ST_PHASE_ALIGN_LOCK    = 1;
   localparam int ST_PHASE_ALIGN_LOCK_SECONDARY    = 2;
   localparam int ST_CALDONE = 3;
   localparam int ST_PASS    = 4;
   localparam int ST_FAIL    = 5;
   localparam int ST_TMO     = 6;
   localparam int ST_RAVB    = 7;
   localparam int ST_RAVA    = 8;
   localparam int ST_PARITY  = 9;

   // control bit positions and reset value
   localparam int CT_TGRST = 0;
   localparam int CT_STOP  = 1;
   localparam int CT_GRSTN = 2;
   localparam logic [2:0] CTRL_RESET = 3'h5;

   // interrupt event bits
   localparam int IRQ_W    = 4;
   localparam int EV_PASS  = 0;
   localparam int EV_FAIL  = 1;
   localparam int EV_TMO   = 2;
   localparam int EV_CAL   = 3;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef enum logic [1:0] {
      CAP_IDLE  = 2'b00,
      CAP_AFTER = 2'b01,
      CAP_DONE  = 2'b11
   } cap_state_t;

   typedef struct packed {
      logic              valid;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] expected;
      logic [DATA_W-1:0] actual;
   } rd_check_t;

   typedef struct packed {
      logic req;
      logic isRead;
      logic stall;
   } req_obs_t;

   typedef struct packed {
      logic [11:0] addr;
      logic        write;
      logic        sel;
   } ahb_addr_t;

endpackage

//--- verif/mem_traffic_model.sv
/*
 * far-side traffic model: two write requests, then checked reads, and one
 * reread at the first failing address. assumes the bench sets salt, errMask,
 * failIdx and nReads while the generator reset is high.
 */
`timescale 1ns/1ps
module mem_traffic_model
   import traffic_probe_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              tgReset,
   input  wire logic              halt,
   input  wire logic              reread,
   input  wire logic [ADDR_W-1:0] rereadAddr,
   input  wire logic [31:0]       salt,
   input  wire logic [127:0]      errMask,
   input  wire logic [7:0]        failIdx,
   input  wire logic [7:0]        nReads,
   output rd_check_t              rdCheck,
   output req_obs_t               reqObs,
   output logic                   pass,
   output logic                   fail,
   output logic                   done
);
   int   step;
   int   idx;
   int   rrWait;
   logic bad;
   assign idx = step - 2;
   always @(posedge clk) begin
      rdCheck.valid <= 1'b0;
      // idle data lines toggle so a stale capture cannot look right
      rdCheck.addr <= ~rdCheck.addr;
      rdCheck.expected <= ~rdCheck.expected;
      rdCheck.actual <= ~rdCheck.actual;
      reqObs <= '0;
      if (tgReset !== 1'b0) begin
         step <= 0;
         rrWait <= 0;
         bad <= 1'b0;
         {pass, fail, done} <= 3'h0;
      end else if (rrWait == 1) begin
         rrWait <= 0;
         reqObs <= 3'b110;
         // hard fault: the reread fails on the same bits again
         rdCheck <= {1'b1, rereadAddr, {4{salt}}, {4{salt}} ^ errMask};
      end else begin
         rrWait <= (reread === 1'b1) ? 2 : (rrWait > 0 ? rrWait - 1 : 0);
         if (step < 2) begin
            reqObs <= 3'b100;
            step <= step + 1;
         end else if (idx < nReads && halt !== 1'b1) begin
            reqObs <= 3'b110;
            rdCheck <= {1'b1, {salt[30:8], 8'h00} + 31'(idx), {4{salt + 32'(idx)}},
                        {4{salt + 32'(idx)}} ^ (idx == failIdx ? errMask : 128'h0)};
            bad <= bad | (idx == failIdx);
            step <= step + 1;
         end else if (idx == nReads && rrWait == 0 && reread !== 1'b1) begin
            done <= 1'b1;
            pass <= !bad;
            fail <= bad;
         end
      end
   end
endmodule

//--- verif/traffic_checker_status_probes_bench.sv
/*
 * self-checking bench: ahb-lite master tasks, traffic model, expected values
 * kept in bench arrays. assumes zero-wait slave and one core clock.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
   $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module traffic_checker_status_probes_bench
   import traffic_probe_pkg::*;
;
   logic clk, resetn, hsel, hwrite, hreadyout, hresp, irq, done, tgPass, tgFail, tgTimeout;
   logic clkgenLockIn, phaseAlignIn, phaseAlignSecIn, calibDoneIn, parityErrIn, parityEnable;
   logic traffic_gen_reset, global_reset_n, stop_on_error_mode, haltTraffic, rereadReq;
   logic [1:0]        htrans;
   logic [31:0]       haddr, hwdata, hrdata, salt, seed, v, c1;
   logic [127:0]      errMask;
   logic [127:0]      wide [9];
   logic [7:0]        failIdx, nReads;
   logic [ADDR_W-1:0] rereadAddr;
   logic              par;
   rd_check_t         rdCheck;
   req_obs_t          reqObs;
   int                err_count, n_checks, i;

   traffic_checker_status i_dut (.clk(clk), .resetn(resetn), .clkEn(1'b1), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .clkgenLockIn(clkgenLockIn), .phaseAlignIn(phaseAlignIn),
      .phaseAlignSecIn(phaseAlignSecIn), .calibDoneIn(calibDoneIn), .parityErrIn(parityErrIn),
      .parityEnable(parityEnable), .rdCheck(rdCheck), .reqObs(reqObs), .tgPass(tgPass),
      .tgFail(tgFail), .tgTimeout(tgTimeout), .traffic_gen_reset(traffic_gen_reset),
      .global_reset_n(global_reset_n), .stop_on_error_mode(stop_on_error_mode),
      .haltTraffic(haltTraffic), .rereadReq(rereadReq), .rereadAddr(rereadAddr), .irq(irq));
   mem_traffic_model i_model (.clk(clk), .tgReset(traffic_gen_reset), .halt(haltTraffic),
      .reread(rereadReq), .rereadAddr(rereadAddr), .salt(salt), .errMask(errMask),
      .failIdx(failIdx), .nReads(nReads), .rdCheck(rdCheck), .reqObs(reqObs),
      .pass(tgPass), .fail(tgFail), .done(done));

   always #2 clk = ~clk;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [127:0] pat(input int k);
      return {4{salt + 32'(k)}};
   endfunction
   task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(a, 1'b1, d, x);
   endtask
   task automatic rd(input logic [11:0] a);
      bus(a, 1'b0, 32'h0, v);
   endtask
   task automatic expect_rd(input logic [11:0] a, input logic [31:0] e);
      rd(a);
      `CHK(v, e)
   endtask
   task automatic run(input logic [7:0] f, input logic [31:0] ctrl);
      wr(OFS_CONTROL, 32'h5);
      salt <= rnd();
      errMask <= {rnd(), rnd(), rnd(), rnd() | 32'h1};
      failIdx <= f;
      wr(OFS_CONTROL, ctrl);
      i = 0;
      while (done !== 1'b1 && haltTraffic !== 1'b1 && i < 300) begin
         @(posedge clk);
         i++;
      end
      if (i >= 300) err_count++;
      repeat (20) @(posedge clk);
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      #120000;
      err_count++;
      finish_test();
   end

   initial begin
      {clk, resetn, hsel, hwrite, htrans, haddr, hwdata, tgTimeout} = '0;
      {clkgenLockIn, phaseAlignIn, phaseAlignSecIn, calibDoneIn, parityErrIn} = '0;
      {parityEnable, err_count, n_checks, errMask, failIdx} = '0;
      seed = 32'h7ed0aa37;
      salt = 32'h0;
      nReads = 8'h08;
      repeat (12) @(posedge clk);
      `CHK(global_reset_n, 1'b0)
      resetn <= 1'b1;
      @(posedge clk);
      `CHK(traffic_gen_reset, 1'b1)
      `CHK(stop_on_error_mode, 1'b0)
      expect_rd(OFS_CONTROL, 32'h5);
      expect_rd(OFS_WIDE_BASE + 12'h060, 32'hffffffff);
      expect_rd(OFS_READ_CNT, 32'h0);
      wr(OFS_IRQ_MASK, 32'hf);
      calibDoneIn <= 1'b1;
      repeat (8) @(posedge clk);
      `CHK(irq, 1'b1)
      rd(OFS_STATUS);
      `CHK(v[ST_CALDONE], 1'b1)
      expect_rd(OFS_IRQ_STAT, 32'h8);
      #1 `CHK(irq, 1'b0)
      rd(OFS_CAL_CNT);
      c1 = v;
      rd(OFS_CAL_CNT);
      `CHK((c1 == v) && (c1 != 32'h0), 1'b1)
      // failing run with stop mode off: after-fail read is the next one
      run(8'h03, 32'h4);
      `CHK(irq, 1'b1)
      expect_rd(OFS_IRQ_STAT, 32'h2);
      rd(OFS_STATUS);
      `CHK(v[8:4], 5'b11010)
      expect_rd(OFS_READ_CNT, 32'h9);
      expect_rd(OFS_FAIL_CNT, 32'h2);
      expect_rd(OFS_FAIL_ADDR, {1'b0, salt[30:8], 8'h03});
      `CHK(rereadAddr, {salt[30:8], 8'h03})
      expect_rd(OFS_REQ_CNT, 32'd11);
      expect_rd(OFS_RDREQ_CNT, 32'd9);
      rd(OFS_CLK_CNT);
      `CHK(v > 32'd10, 1'b1)
      wide = '{pat(3), pat(2), pat(4), pat(3) ^ errMask, pat(2), pat(4), ~errMask, ~errMask,
               ~errMask};
      for (int b = 0; b < WIDE_BANKS * 4; b++)
         expect_rd(OFS_WIDE_BASE + 12'(4 * b), wide[b / 4][32 * (b % 4) +: 32]);
      // clean run with every event masked
      wr(OFS_IRQ_MASK, 32'h0);
      run(8'hc8, 32'h4);
      `CHK(irq, 1'b0)
      expect_rd(OFS_IRQ_STAT, 32'h1);
      expect_rd(OFS_READ_CNT, 32'h8);
      expect_rd(OFS_FAIL_CNT, 32'h0);
      run(8'h02, 32'h6);
      `CHK(haltTraffic, 1'b1)
      `CHK(stop_on_error_mode, 1'b1)
      expect_rd(OFS_READ_CNT, 32'h5);
      expect_rd(OFS_FAIL_CNT, 32'h2);
      wr(OFS_CONTROL, 32'h1);
      #1 `CHK(global_reset_n, 1'b0)
      wr(OFS_CONTROL, 32'h5);
      par = 1'b0;
      for (int k = 0; k < 4; k++) begin
         {clkgenLockIn, phaseAlignIn, phaseAlignSecIn, parityErrIn} <= 4'(rnd());
         parityEnable <= (k < 2);
         repeat (6) @(posedge clk);
         if (k < 2) par = parityErrIn;
         rd(OFS_STATUS);
         `CHK(v[2:0], {phaseAlignSecIn, phaseAlignIn, clkgenLockIn})
         `CHK(v[ST_PARITY], par)
      end
      wr(OFS_CONTROL, 32'h6);
      tgTimeout <= 1'b1;
      repeat (4) @(posedge clk);
      rd(OFS_STATUS);
      `CHK(v[ST_TMO], 1'b1)
      expect_rd(OFS_IRQ_STAT, 32'h4);
      expect_rd(12'h0fc, 32'h0);
      finish_test();
   end
endmodule
